// ---- verilog/cmd_bus_train_loopback.sv ----
// command bus training loopback with axi4-lite control
`timescale 1ns/1ps
`default_nettype none
module cmd_bus_train_loopback #(
  parameter int SETTLE_QTRS = cmd_train_pkg::ENTRY_SETTLE_QTRS,
  parameter int SLX_QTRS    = cmd_train_pkg::SLEEP_EXIT_QTRS,
  parameter int LOOP_QTRS   = cmd_train_pkg::LOOPBACK_QTRS,
  parameter int EXIT_TIME_Q = cmd_train_pkg::EXIT_QTRS
) (
  // clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // axi4-lite write
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [3:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // axi4-lite read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [3:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // entry triggers from the command decoder and sleep logic
  input  wire logic        train_entry_cmd,
  input  wire logic        parity_err,
  input  wire logic        sleep_exit,
  input  wire logic        selfref_sleep_exit,
  output logic             cmd_decode_en,
  // pins
  input  wire logic        write_clock,
  input  wire logic [4:0]  cmd_addr_bus,
  input  wire logic        phase_select_in,
  output logic [9:0]       dq_out,
  output logic             dq_oe,
  output logic             dq_three_level,
  output logic             return_clock_true,
  output logic             return_clock_comp,
  output logic             return_clock_oe,
  output logic             return_clock_diff,
  output logic             return_clock_full_swing
);
  localparam int CW = 8;
  cmd_train_pkg::ctrl_t  ctrl_q;
  cmd_train_pkg::state_t state_q;
  logic [3:0]  aw_addr_q;
  logic [7:0]  w_data_q;
  logic        w_strb_q;
  logic [2:0]  wck_s_q;
  logic [4:0]  ca_s1_q;
  logic [4:0]  ca_s2_q;
  logic [1:0]  sel_s_q;
  logic        sel_q;
  logic [1:0]  qph_q;
  logic [4:0]  low_cnt_q;
  logic [CW-1:0] qcnt_q;
  logic [CW-1:0] settle_lim_q;
  logic [9:0]  cap_q;
  logic        cap_ok_q;
  logic [9:0]  pipe_q [LOOP_QTRS];
  logic [LOOP_QTRS-1:0] pvld_q;
  logic        wedge;
  logic        qstart;
  logic        exit_seen;
  logic        entry;

  // write clock edges and quarter phase boundaries
  assign wedge  = wck_s_q[1] & ~wck_s_q[2];
  assign qstart = wedge & (qph_q == 2'h0);
  assign exit_seen = wedge && (ca_s2_q == '0) &&
                     (low_cnt_q == 5'(cmd_train_pkg::EXIT_LOW_WCKS - 1));
  assign entry = train_entry_cmd | (parity_err & ctrl_q.parity_block) |
                 (sleep_exit & ctrl_q.slx_flag) |
                 (selfref_sleep_exit & ctrl_q.srslx_flag);

  // two-flop synchronisers for pins
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wck_s_q <= '0;
      ca_s1_q <= '0;
      ca_s2_q <= '0;
      sel_s_q <= '0;
    end else if (clk_en) begin
      wck_s_q <= {wck_s_q[1:0], write_clock};
      ca_s1_q <= cmd_addr_bus;
      ca_s2_q <= ca_s1_q;
      sel_s_q <= {sel_s_q[0], phase_select_in};
    end
  end

  // quarter phase counter and per-quartet phase pair snapshot
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      qph_q <= 2'h0;
      sel_q <= 1'b1;
    end else if (clk_en && wedge) begin
      qph_q <= qph_q + 2'h1;
      if (qph_q == 2'h0)
        sel_q <= sel_s_q[1];
    end
  end

  // training state machine, reset itself enters training
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q      <= cmd_train_pkg::ST_SETTLE;
      qcnt_q       <= '0;
      settle_lim_q <= CW'(SETTLE_QTRS);
    end else if (clk_en) begin
      case (state_q)
        cmd_train_pkg::ST_IDLE: begin
          qcnt_q <= '0;
          if (entry) begin
            state_q      <= cmd_train_pkg::ST_SETTLE;
            settle_lim_q <= ((sleep_exit & ctrl_q.slx_flag) |
                            (selfref_sleep_exit & ctrl_q.srslx_flag)) ?
                            CW'(SLX_QTRS) : CW'(SETTLE_QTRS);
          end
        end
        cmd_train_pkg::ST_SETTLE: begin
          if (exit_seen) begin
            state_q <= cmd_train_pkg::ST_EXIT;
            qcnt_q  <= '0;
          end else if (qstart) begin
            qcnt_q <= qcnt_q + CW'(1);
            if (qcnt_q + CW'(1) >= settle_lim_q)
              state_q <= cmd_train_pkg::ST_LOOP;
          end
        end
        cmd_train_pkg::ST_LOOP: begin
          qcnt_q <= '0;
          if (exit_seen)
            state_q <= cmd_train_pkg::ST_EXIT;
        end
        cmd_train_pkg::ST_EXIT: begin
          if (qstart) begin
            qcnt_q <= qcnt_q + CW'(1);
            if (qcnt_q + CW'(1) >= CW'(EXIT_TIME_Q))
              state_q <= cmd_train_pkg::ST_IDLE;
          end
        end
        default: state_q <= cmd_train_pkg::ST_IDLE;
      endcase
    end
  end

  // consecutive all-low count on the command bus
  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      low_cnt_q <= '0;
    else if (clk_en && wedge) begin
      if (ca_s2_q != '0 || state_q == cmd_train_pkg::ST_IDLE ||
          state_q == cmd_train_pkg::ST_EXIT || exit_seen)
        low_cnt_q <= '0;
      else
        low_cnt_q <= low_cnt_q + 5'h1;
    end
  end

  // capture of the selected phase pair onto lane pairs
  for (genvar n = 0; n < cmd_train_pkg::CMD_LANES; n++) begin : g_lane
    always_ff @(posedge clk_sys) begin
      if (!reset_n)
        cap_q[2*n+1 -: 2] <= '0;
      else if (clk_en && wedge) begin
        if (qph_q == {~sel_q, 1'b0})
          cap_q[2*n] <= ca_s2_q[n];
        if (qph_q == {~sel_q, 1'b1})
          cap_q[2*n+1] <= ca_s2_q[n];
      end
    end
  end

  // fixed-depth loopback pipeline, one word per quartet
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cap_ok_q <= 1'b0;
      pvld_q   <= '0;
      for (int i = 0; i < LOOP_QTRS; i++)
        pipe_q[i] <= '0;
    end else if (clk_en) begin
      if (state_q == cmd_train_pkg::ST_EXIT || state_q == cmd_train_pkg::ST_IDLE) begin
        cap_ok_q <= 1'b0;
        pvld_q   <= '0;
      end else if (qstart) begin
        cap_ok_q  <= (state_q == cmd_train_pkg::ST_LOOP);
        pipe_q[0] <= cap_q;
        pvld_q[0] <= cap_ok_q && (state_q == cmd_train_pkg::ST_LOOP);
        for (int i = 1; i < LOOP_QTRS; i++) begin
          pipe_q[i] <= pipe_q[i-1];
          pvld_q[i] <= pvld_q[i-1];
        end
      end
    end
  end

  // data lane drive, updated on phase zero with the clock rise
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      dq_out         <= '0;
      dq_oe          <= 1'b0;
      dq_three_level <= 1'b0;
    end else if (clk_en) begin
      dq_three_level <= ctrl_q.three_level;
      if (state_q != cmd_train_pkg::ST_LOOP)
        dq_oe <= 1'b0;
      else if (qstart) begin
        dq_out <= pipe_q[LOOP_QTRS-1];
        dq_oe  <= pvld_q[LOOP_QTRS-1];
      end
    end
  end

  // return clock: quarter rate in settle and loop, mode field otherwise (idle and exit)
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      return_clock_true       <= 1'b0;
      return_clock_comp       <= 1'b1;
      return_clock_oe         <= 1'b1;
      return_clock_diff       <= 1'b1;
      return_clock_full_swing <= 1'b1;
    end else if (clk_en) begin
      if (state_q == cmd_train_pkg::ST_SETTLE || state_q == cmd_train_pkg::ST_LOOP) begin
        return_clock_oe         <= 1'b1;
        return_clock_diff       <= 1'b1;
        return_clock_full_swing <= 1'b1;
        if (wedge) begin
          return_clock_true <= ~qph_q[1];
          return_clock_comp <= qph_q[1];
        end
      end else begin
        return_clock_diff       <= ctrl_q.rck_type;
        return_clock_full_swing <= ctrl_q.rck_level;
        if (ctrl_q.rck_mode == cmd_train_pkg::RCK_ALWAYS_ON) begin
          return_clock_oe   <= 1'b1;
          return_clock_true <= wck_s_q[1];
          return_clock_comp <= ~wck_s_q[1];
        end else begin
          return_clock_oe   <= 1'b0;
          return_clock_true <= 1'b0;
          return_clock_comp <= 1'b1;
        end
      end
    end
  end

  // normal command decode only outside training
  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      cmd_decode_en <= 1'b0;
    else if (clk_en)
      cmd_decode_en <= (state_q == cmd_train_pkg::ST_IDLE) && !entry;
  end

  // axi4-lite write channel
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= cmd_train_pkg::RESP_OKAY;
      aw_addr_q <= 4'hf;
      w_data_q  <= '0;
      w_strb_q  <= 1'b0;
      ctrl_q    <= cmd_train_pkg::ctrl_t'(cmd_train_pkg::CTRL_RST);
    end else if (clk_en) begin
      if (bvalid) begin
        if (bready) begin
          bvalid  <= 1'b0;
          awready <= 1'b1;
          wready  <= 1'b1;
        end
      end else if (!awready && !wready && aw_addr_q != 4'hf) begin
        bvalid <= 1'b1;
        if (aw_addr_q == cmd_train_pkg::CTRL_OFS) begin
          bresp <= cmd_train_pkg::RESP_OKAY;
          if (w_strb_q)
            ctrl_q <= cmd_train_pkg::ctrl_t'(w_data_q);
        end else if (aw_addr_q == cmd_train_pkg::STATUS_OFS)
          bresp <= cmd_train_pkg::RESP_OKAY;
        else
          bresp <= cmd_train_pkg::RESP_SLVERR;
      end else begin
        if (aw_addr_q == 4'hf) begin
          awready   <= 1'b1;
          wready    <= 1'b1;
          aw_addr_q <= '0;
        end
        if (awvalid && awready) begin
          awready   <= 1'b0;
          aw_addr_q <= awaddr;
        end
        if (wvalid && wready) begin
          wready   <= 1'b0;
          w_data_q <= wdata[7:0];
          w_strb_q <= wstrb[0];
        end
      end
    end
  end

  // axi4-lite read channel
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= cmd_train_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (rvalid) begin
        if (rready) begin
          rvalid  <= 1'b0;
          arready <= 1'b1;
        end
      end else if (!arready) begin
        arready <= 1'b1;
      end else if (arvalid) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= cmd_train_pkg::RESP_OKAY;
        if (araddr == cmd_train_pkg::CTRL_OFS)
          rdata <= {24'h0, ctrl_q};
        else if (araddr == cmd_train_pkg::STATUS_OFS)
          rdata <= {21'h0, qph_q, low_cnt_q, sel_q, dq_oe, state_q};
        else begin
          rdata <= '0;
          rresp <= cmd_train_pkg::RESP_SLVERR;
        end
      end
    end
  end
endmodule // cmd_bus_train_loopback
`default_nettype wire

// ---- common/cmd_train_pkg.sv ----
// constants and types for the command bus training loopback block
package cmd_train_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // return clock mode field encodings
  localparam logic [1:0] RCK_DISABLED   = 2'h0;
  localparam logic [1:0] RCK_START_STOP = 2'h1;
  localparam logic [1:0] RCK_READ_STOP  = 2'h2;
  localparam logic [1:0] RCK_ALWAYS_ON  = 2'h3;
  // timing counts in quarter-clock cycles, exit pattern in write clock cycles
  localparam int ENTRY_SETTLE_QTRS = 7;
  localparam int SLEEP_EXIT_QTRS   = 7;
  localparam int LOOPBACK_QTRS     = 4;
  localparam int EXIT_QTRS         = 6;
  localparam int EXIT_LOW_WCKS     = 16;
  localparam int CMD_LANES         = 5;
  localparam int DQ_LANES          = 10;
  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       rck_level;
    logic       rck_type;
    logic [1:0] rck_mode;
    logic       srslx_flag;
    logic       slx_flag;
    logic       parity_block;
    logic       three_level;
  } ctrl_t;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_SETTLE = 2'h1,
    ST_LOOP   = 2'h3,
    ST_EXIT   = 2'h2
  } state_t;
endpackage

// ---- verification/cmd_bus_train_loopback_asserts.sv ----
// port assertions for the training loopback
`timescale 1ns/1ps
`default_nettype none
module cmd_bus_train_loopback_asserts (
  // clock, reset
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // observed outputs
  input wire logic       cmd_decode_en,
  input wire logic [9:0] dq_out,
  input wire logic       dq_oe,
  input wire logic       return_clock_true,
  input wire logic       return_clock_comp,
  input wire logic       return_clock_oe,
  input wire logic       return_clock_diff,
  input wire logic       return_clock_full_swing
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_quiet;
    cmd_decode_en |-> !dq_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("dq in decode");
  property p_diff;
    dq_oe |-> return_clock_diff && return_clock_full_swing && return_clock_oe;
  endproperty
  a_diff: assert property (p_diff) else $error("rck drive");
  property p_comp;
    dq_oe |-> return_clock_comp != return_clock_true;
  endproperty
  a_comp: assert property (p_comp) else $error("rck pair");
  property p_first;
    $rose(dq_oe) |-> $rose(return_clock_true) && $past(return_clock_oe);
  endproperty
  a_first: assert property (p_first) else $error("first dq");
  property p_edge;
    dq_oe && $past(dq_oe) && dq_out != $past(dq_out) |-> $rose(return_clock_true);
  endproperty
  a_edge: assert property (p_edge) else $error("dq edge");
  property p_off;
    $rose(cmd_decode_en) |-> !dq_oe && !$past(dq_oe);
  endproperty
  a_off: assert property (p_off) else $error("dq at exit");
  property p_stop;
    $fell(dq_oe) |-> ##[1:1000] cmd_decode_en;
  endproperty
  a_stop: assert property (p_stop) else $error("exit long");
  property p_idle;
    cmd_decode_en && !return_clock_oe |-> !return_clock_true;
  endproperty
  a_idle: assert property (p_idle) else $error("rck idle");
endmodule // cmd_bus_train_loopback_asserts
bind cmd_bus_train_loopback cmd_bus_train_loopback_asserts i_cmd_bus_train_loopback_asserts (
  .clk_sys, .reset_n, .cmd_decode_en, .dq_out, .dq_oe, .return_clock_true,
  .return_clock_comp, .return_clock_oe, .return_clock_diff, .return_clock_full_swing);
`default_nettype wire

// ---- verification/host_model.sv ----
// host model: write clock, command bus, phase select
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // pins
  output var logic       write_clock,
  output var logic [4:0] cmd_addr_bus,
  output var logic       phase_select_in
);
  logic [4:0] pat [4];
  int         k = 0;
  int         hi = 0;
  int         lo = 0;
  logic       idle = 1'b1;
  initial begin
    write_clock = 1'b0;
    cmd_addr_bus = 5'h1f;
    phase_select_in = 1'b1;
    #37;
    forever #80 write_clock = ~write_clock;
  end
  always @(posedge write_clock) k <= k + 1;
  always @(negedge write_clock) begin
    if (hi > 0) begin
      cmd_addr_bus <= 5'h1f;
      hi <= hi - 1;
    end else if (lo > 0) begin
      cmd_addr_bus <= 5'h00;
      lo <= lo - 1;
    end else if (idle) cmd_addr_bus <= 5'h1f;
    else cmd_addr_bus <= pat[(k + 1) % 4];
  end
  task automatic set_sel(input logic v);
    hi = 9;
    repeat (4) @(negedge write_clock);
    phase_select_in = v;
  endtask
  task automatic leave();
    hi = 4;
    lo = 16;
    idle = 1'b1;
  endtask
endmodule // host_model
`default_nettype wire

// ---- verification/cmd_bus_train_loopback_tb.sv ----
// self-checking bench for the training loopback
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module cmd_bus_train_loopback_tb;
  logic        clk_sys = 1'b0, reset_n = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf, trig = 4'h0;
  logic [31:0] wdata = 32'h0, seed = 32'h1c19, rdata, rd;
  logic        awready, wready, bvalid, arready, rvalid, cmd_decode_en, write_clock;
  logic        phase_select_in, dq_oe, dq_three_level, return_clock_true, return_clock_oe;
  logic [1:0]  bresp, rresp, rs;
  logic [4:0]  cmd_addr_bus;
  logic [9:0]  dq_out, e;
  int          err_count = 0, compares = 0;
  always #5 clk_sys = ~clk_sys;
  cmd_bus_train_loopback #(.SETTLE_QTRS(2), .SLX_QTRS(2), .LOOP_QTRS(2), .EXIT_TIME_Q(2))
    i_cmd_bus_train_loopback (.clk_sys, .reset_n, .clk_en(1'b1), .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .train_entry_cmd(trig[0]), .parity_err(trig[1]),
    .sleep_exit(trig[2]), .selfref_sleep_exit(trig[3]), .cmd_decode_en, .write_clock,
    .cmd_addr_bus, .phase_select_in, .dq_out, .dq_oe, .dq_three_level, .return_clock_true,
    .return_clock_comp(), .return_clock_oe, .return_clock_diff(), .return_clock_full_swing());
  host_model i_host_model (.write_clock, .cmd_addr_bus, .phase_select_in);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [9:0] exp_dq(input logic [4:0] a, input logic [4:0] b);
    logic [9:0] v;
    for (int n = 0; n < 5; n++) begin
      v[2 * n] = a[n];
      v[2 * n + 1] = b[n];
    end
    return v;
  endfunction
  task automatic finish_test();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tmo();
    err_count++;
    $display("[ERR] wait exp done got timeout");
    finish_test();
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 99; i++) begin
      @(posedge clk_sys);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    rs = bresp;
    bready <= 1'b0;
    if (i == 99) tmo();
  endtask
  task automatic axi_rd(input logic [3:0] a);
    int i;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 99; i++) begin
      @(posedge clk_sys);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (i == 99) tmo();
  endtask
  task automatic wait_rck(input int n);
    int i;
    logic pv;
    pv = 1'b1;
    for (i = 0; i < 9999 && n > 0; i++) begin
      @(posedge clk_sys);
      if (return_clock_true === 1'b1 && !pv) n--;
      pv = return_clock_true;
    end
    if (n > 0) tmo();
  endtask
  task automatic pulse(input int t);
    @(posedge clk_sys);
    trig[t] <= 1'b1;
    @(posedge clk_sys);
    trig <= 4'h0;
    clk(3);
  endtask
  task automatic round(input logic s, input logic tl);
    logic [31:0] r;
    int o;
    r = xs();
    i_host_model.pat = '{r[4:0] | 5'h01, r[9:5] | 5'h01, r[14:10], r[19:15]};
    i_host_model.idle = 1'b0;
    i_host_model.set_sel(s);
    wait_rck(9);
    o = s ? i_host_model.k : i_host_model.k + 2;
    clk(2);
    e = exp_dq(i_host_model.pat[o % 4], i_host_model.pat[(o + 1) % 4]);
    `CHK("dq_oe", 1'b1, dq_oe)
    `CHK("level", tl, dq_three_level)
    `CHK("dq", e, dq_out)
  endtask
  task automatic leave(input logic aon);
    int i;
    i_host_model.leave();
    for (i = 0; i < 999 && dq_oe !== 1'b0; i++) clk(1);
    `CHK("decode", 1'b0, cmd_decode_en)
    for (i = 0; i < 999 && cmd_decode_en !== 1'b1; i++) clk(1);
    if (i == 999) tmo();
    clk(1);
    `CHK("rck_oe", aon, return_clock_oe)
    axi_rd(cmd_train_pkg::STATUS_OFS);
    `CHK("state", cmd_train_pkg::ST_IDLE, rd[1:0])
  endtask
  initial begin
    cmd_train_pkg::ctrl_t c;
    logic [31:0] r;
    clk(4);
    reset_n <= 1'b1;
    clk(2);
    `CHK("decode", 1'b0, cmd_decode_en)
    axi_rd(cmd_train_pkg::CTRL_OFS);
    `CHK("ctrl", {24'h0, cmd_train_pkg::CTRL_RST}, rd)
    axi_rd(4'h8);
    `CHK("resp", cmd_train_pkg::RESP_SLVERR, rs)
    `CHK("rdata", 32'h0, rd)
    round(1'b0, 1'b0);
    round(1'b1, 1'b0);
    leave(1'b0);
    for (int t = 0; t < 4; t++) begin
      r = xs();
      c = r[7:0];
      c[3:1] = 3'h0;
      c.rck_mode = t[1:0];
      if (t > 0) begin
        axi_wr(cmd_train_pkg::CTRL_OFS, {24'h0, c});
        pulse(t);
        `CHK("no_entry", 1'b1, cmd_decode_en)
        c[t] = 1'b1;
      end
      axi_wr(cmd_train_pkg::CTRL_OFS, {24'h0, c});
      `CHK("bresp", cmd_train_pkg::RESP_OKAY, rs)
      pulse(t);
      `CHK("entry", 1'b0, cmd_decode_en)
      round(1'b1, c.three_level);
      round(1'b0, c.three_level);
      leave(c.rck_mode == cmd_train_pkg::RCK_ALWAYS_ON);
    end
    finish_test();
  end
endmodule // cmd_bus_train_loopback_tb
`default_nettype wire
